// File: design/rlsl_pkg.sv
// Package of constants shared by both ends of the reference level loader
package rlsl_pkg;
    // ==========================================================
    // Command word layout
    localparam int WORD_BITS = 16;
    localparam int TEST_BIT = 15;
    localparam int SRC_BIT = 14;
    localparam int CHAN_MSB = 13;
    localparam int CHAN_LSB = 10;
    localparam int LEVEL_MSB = 9;
    localparam int LEVEL_LSB = 0;
    localparam int CHAN_W = 4;
    localparam int LEVEL_W = 10;
    localparam int NUM_CHAN = 12;
    localparam logic [CHAN_W-1:0] CHAN_LAST = 4'hb;
    localparam logic [LEVEL_W-1:0] LEVEL_RST = 10'h000;
    localparam logic SRC_INTERNAL = 1'b0;
    localparam logic SRC_EXTERNAL = 1'b1;
    localparam logic [4:0] BIT_COUNT_FULL = 5'h10;
    // ==========================================================
    // Timing
    localparam int CORE_CLK_HZ = 40000000;
    localparam int SCLK_MAX_HZ = 5000000;
    localparam int SCLK_HALF_CYC = (CORE_CLK_HZ + 2 * SCLK_MAX_HZ - 1) /
        (2 * SCLK_MAX_HZ);
    localparam int OSC_HZ = 21000;
    localparam int OSC_HALF_CYC = CORE_CLK_HZ / (2 * OSC_HZ);
    localparam int EDGE_GAP_CYC = 2;
endpackage

// File: design/rlsl_link_if.sv
// Four-wire serial link between host controller and loader device
`timescale 1ns/1ps
`default_nettype none
interface rlsl_link_if;
    logic selectN;
    logic shiftClk;
    logic serialIn;
    logic serialOut;
    modport host (output selectN, output shiftClk, output serialIn,
        input serialOut);
    modport device (input selectN, input shiftClk, input serialIn,
        output serialOut);
endinterface
`default_nettype wire

// File: design/rlsl_device.sv
// Device end: serial command loader with twelve level channels
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module rlsl_device #(
    parameter int OSC_HALF = rlsl_pkg::OSC_HALF_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Serial link
    rlsl_link_if.device link,
    // Refresh clock pin
    input wire logic refreshClkIn,
    output logic refreshClkOut,
    output logic refreshClkOe,
    // Channel state
    output logic [rlsl_pkg::NUM_CHAN*rlsl_pkg::LEVEL_W-1:0] channelLevels,
    output logic clockSource,
    output logic refreshStrobe,
    output logic switchOpenStrobe,
    output logic updatePulse
);
    import rlsl_pkg::*;

    // ==========================================================
    // Input synchronisers
    logic [1:0] selSync_r;
    logic [1:0] sclkSync_r;
    logic [1:0] sdiSync_r;
    logic [1:0] rclkSync_r;
    logic sclkPrev_r;
    logic selPrev_r;
    logic rclkPrev_r;
    logic selLow;
    logic sclkRise;
    logic sclkFall;
    logic selRise;

    // Two flip-flops on every pin input
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            selSync_r <= 2'h3;
            sclkSync_r <= 2'h0;
            sdiSync_r <= 2'h0;
            rclkSync_r <= 2'h0;
        end else begin
            selSync_r <= {selSync_r[0], link.selectN};
            sclkSync_r <= {sclkSync_r[0], link.shiftClk};
            sdiSync_r <= {sdiSync_r[0], link.serialIn};
            rclkSync_r <= {rclkSync_r[0], refreshClkIn};
        end
    end

    // Previous values for edge detection
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sclkPrev_r <= 1'b0;
            selPrev_r <= 1'b1;
            rclkPrev_r <= 1'b0;
        end else begin
            sclkPrev_r <= sclkSync_r[1];
            selPrev_r <= selSync_r[1];
            rclkPrev_r <= rclkSync_r[1];
        end
    end

    assign selLow = !selSync_r[1];
    assign sclkRise = selLow && sclkSync_r[1] && !sclkPrev_r;
    assign sclkFall = selLow && !sclkSync_r[1] && sclkPrev_r;
    assign selRise = selSync_r[1] && !selPrev_r;

    // ==========================================================
    // Shift register and bit counter
    logic [WORD_BITS-1:0] shift_r;
    logic [4:0] bitCount_r;
    logic sdo_r;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            shift_r <= '0;
        end else if (sclkRise) begin
            shift_r <= {shift_r[WORD_BITS-2:0], sdiSync_r[1]};
        end
    end

    // count bits, saturating at a full word
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bitCount_r <= 5'h00;
        end else if (selRise) begin
            bitCount_r <= 5'h00;
        end else if (sclkRise && bitCount_r != BIT_COUNT_FULL) begin
            bitCount_r <= bitCount_r + 5'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sdo_r <= 1'b0;
        end else if (sclkFall) begin
            sdo_r <= shift_r[WORD_BITS-1];
        end
    end
    assign link.serialOut = sdo_r;

    // ==========================================================
    // Command decode and channel storage
    logic [LEVEL_W-1:0] level_r [NUM_CHAN];
    logic src_r;
    logic srcWritten_r;
    logic upd_r;
    logic cmdValid;
    logic [CHAN_W-1:0] chanIdx;

    assign chanIdx = shift_r[CHAN_MSB:CHAN_LSB];
    // update on select rise after full word
    assign cmdValid = selRise && bitCount_r == BIT_COUNT_FULL;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                level_r[i] <= LEVEL_RST;
            end
        end else if (cmdValid && chanIdx <= CHAN_LAST) begin
            level_r[chanIdx] <= shift_r[LEVEL_MSB:LEVEL_LSB];
        end
    end

    // clock source from every valid command
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            src_r <= SRC_INTERNAL;
            srcWritten_r <= 1'b0;
        end else if (cmdValid) begin
            src_r <= shift_r[SRC_BIT];
            srcWritten_r <= 1'b1;
        end
    end

    // Update pulse one cycle after taking command
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            upd_r <= 1'b0;
        end else begin
            upd_r <= cmdValid;
        end
    end

    // Flatten channel array
    always_comb begin
        for (int i = 0; i < NUM_CHAN; i++) begin
            channelLevels[i*LEVEL_W +: LEVEL_W] = level_r[i];
        end
    end
    assign clockSource = src_r;
    assign updatePulse = upd_r;

    // ==========================================================
    // Refresh oscillator and refresh strobes
    logic [15:0] oscCount_r;
    logic osc_r;
    logic oscPrev_r;
    logic refClk;
    logic refClkPrev;

    // Internal oscillator divider
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            oscCount_r <= 16'h0000;
            osc_r <= 1'b0;
        end else if (oscCount_r == 16'(OSC_HALF - 1)) begin
            oscCount_r <= 16'h0000;
            osc_r <= !osc_r;
        end else begin
            oscCount_r <= oscCount_r + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            oscPrev_r <= 1'b0;
        end else begin
            oscPrev_r <= osc_r;
        end
    end

    // drive pin only once internal source chosen
    assign refreshClkOut = osc_r;
    assign refreshClkOe = srcWritten_r && src_r == SRC_INTERNAL;

    assign refClk = (src_r == SRC_EXTERNAL) ? rclkSync_r[1] : osc_r;
    assign refClkPrev = (src_r == SRC_EXTERNAL) ? rclkPrev_r : oscPrev_r;
    assign refreshStrobe = refClkPrev && !refClk;
    assign switchOpenStrobe = !refClkPrev && refClk;
endmodule
`default_nettype wire

// File: design/rlsl_host.sv
// Host end: sends command words over the four-wire serial link
`timescale 1ns/1ps
`default_nettype none
module rlsl_host #(
    parameter int HALF_CYC = rlsl_pkg::SCLK_HALF_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Serial link
    rlsl_link_if.host link,
    // Register port
    input wire logic [1:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdata
);
    import rlsl_pkg::*;

    // Register offsets
    localparam logic [1:0] ADDR_WORD = 2'h0;
    localparam logic [1:0] ADDR_CTRL = 2'h1;
    localparam logic [1:0] ADDR_STAT = 2'h2;
    localparam logic [1:0] ADDR_RXW = 2'h3;

    typedef enum {ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_HOLD} rlsl_state_e;

    // ==========================================================
    // Registers and state
    rlsl_state_e state_r;
    logic [15:0] txWord_r;
    logic [15:0] rxWord_r;
    logic [15:0] rdata_r;
    logic [7:0] wordsLeft_r;
    logic [3:0] bitIdx_r;
    logic [7:0] timer_r;
    logic sel_r;
    logic sclk_r;
    logic sdi_r;
    logic needWord_r;
    logic done_r;
    logic [1:0] sdoSync_r;
    logic busy;
    logic timerDone;

    assign busy = state_r != ST_IDLE;
    assign timerDone = timer_r == 8'h00;

    // Serial out from the device passes two flip-flops
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sdoSync_r <= 2'h0;
        end else begin
            sdoSync_r <= {sdoSync_r[0], link.serialOut};
        end
    end

    // Frame sequencer; writing CTRL gives number of words, WORD refills
    // MSB first, clock low before select
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
            sel_r <= 1'b1;
            sclk_r <= 1'b0;
            sdi_r <= 1'b0;
            bitIdx_r <= 4'hf;
            timer_r <= 8'h00;
            wordsLeft_r <= 8'h00;
            txWord_r <= 16'h0000;
            rxWord_r <= 16'h0000;
            needWord_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            if (regWrite && regAddr == ADDR_WORD) begin
                txWord_r <= regWdata & ~(16'h0001 << TEST_BIT);
                needWord_r <= 1'b0;
            end
            case (state_r)
                ST_IDLE: begin
                    sclk_r <= 1'b0;
                    if (regWrite && regAddr == ADDR_CTRL &&
                        regWdata[7:0] != 8'h00) begin
                        wordsLeft_r <= regWdata[7:0];
                        done_r <= 1'b0;
                        sel_r <= 1'b0;
                        bitIdx_r <= 4'hf;
                        timer_r <= 8'(HALF_CYC - 1);
                        state_r <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (timerDone && !needWord_r) begin
                        sdi_r <= txWord_r[bitIdx_r];
                        timer_r <= 8'(HALF_CYC - 1);
                        state_r <= ST_LOW;
                    end else if (!timerDone) begin
                        timer_r <= timer_r - 8'h01;
                    end
                end
                ST_LOW: begin
                    if (timerDone) begin
                        sclk_r <= 1'b1;
                        timer_r <= 8'(HALF_CYC - 1);
                        state_r <= ST_HIGH;
                    end else begin
                        timer_r <= timer_r - 8'h01;
                    end
                end
                ST_HIGH: begin
                    if (timerDone) begin
                        sclk_r <= 1'b0;
                        // Serial out as it stood at the rise; the two sync
                        // flops make the rise itself see the older bit
                        rxWord_r <= {rxWord_r[14:0], sdoSync_r[1]};
                        timer_r <= 8'(HALF_CYC - 1);
                        if (bitIdx_r != 4'h0) begin
                            bitIdx_r <= bitIdx_r - 4'h1;
                            sdi_r <= txWord_r[bitIdx_r - 4'h1];
                            state_r <= ST_LOW;
                        end else if (wordsLeft_r != 8'h01) begin
                            wordsLeft_r <= wordsLeft_r - 8'h01;
                            bitIdx_r <= 4'hf;
                            needWord_r <= 1'b1;
                            state_r <= ST_SETUP;
                        end else begin
                            wordsLeft_r <= 8'h00;
                            state_r <= ST_HOLD;
                        end
                    end else begin
                        timer_r <= timer_r - 8'h01;
                    end
                end
                ST_HOLD: begin
                    if (timerDone) begin
                        sel_r <= 1'b1;
                        done_r <= 1'b1;
                        state_r <= ST_IDLE;
                    end else begin
                        timer_r <= timer_r - 8'h01;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    assign link.selectN = sel_r;
    assign link.shiftClk = sclk_r;
    assign link.serialIn = sdi_r;

    // Read data one cycle after strobe
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 16'h0000;
        end else if (regRead) begin
            case (regAddr)
                ADDR_WORD: rdata_r <= txWord_r;
                ADDR_CTRL: rdata_r <= {8'h00, wordsLeft_r};
                ADDR_STAT: rdata_r <= {13'h0000, done_r, needWord_r, busy};
                ADDR_RXW: rdata_r <= rxWord_r;
                default: rdata_r <= 16'h0000;
            endcase
        end else begin
            rdata_r <= 16'h0000;
        end
    end
    assign regRdata = rdata_r;
endmodule
`default_nettype wire

// File: verification/rlsl_props.sv
// Link checker for the reference level loader
`timescale 1ns/1ps
`default_nettype none
module rlsl_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Serial link
    input wire logic selectN,
    input wire logic shiftClk,
    input wire logic serialIn,
    input wire logic serialOut
);
    logic clkPrev_r;
    logic [15:0] hist_r;
    logic [11:0] riseCnt_r;
    wire clkRise = shiftClk && !clkPrev_r;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // ==========================================================
    // Helpers: bits taken at rising shift clock, rises per frame
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            clkPrev_r <= 1'b0;
            hist_r <= 16'h0000;
            riseCnt_r <= 12'h000;
        end else begin
            clkPrev_r <= shiftClk;
            if (clkRise && !selectN) begin
                hist_r <= {hist_r[14:0], serialIn};
                riseCnt_r <= riseCnt_r + 12'h001;
            end else if (selectN) begin
                riseCnt_r <= 12'h000;
            end
        end
    end
    // ==========================================================
    // Link relations
    a_idle_clk_low: assert property (selectN |-> !shiftClk)
        else $error("shift clock high outside a frame");
    a_sel_fall_low: assert property ($fell(selectN) |->
        !shiftClk && !$past(shiftClk))
        else $error("select fell with shift clock high");
    a_high_phase: assert property ($rose(shiftClk) |->
        shiftClk [*4] ##1 !shiftClk)
        else $error("shift clock high phase wrong");
    a_low_phase: assert property ($fell(shiftClk) && !selectN |->
        !shiftClk [*4])
        else $error("shift clock low phase too short");
    a_data_hold: assert property (shiftClk |-> $stable(serialIn))
        else $error("serial input moved while clock high");
    a_frame_bits: assert property ($rose(selectN) |->
        riseCnt_r != 12'h000 && riseCnt_r[3:0] == 4'h0)
        else $error("frame not a whole number of words");
    a_out_delay: assert property ($fell(shiftClk) && !selectN |->
        ##4 serialOut == hist_r[15])
        else $error("serial output not sixteen bits behind");
    a_out_quiet: assert property ($changed(serialOut) |-> !shiftClk)
        else $error("serial output moved while clock high");
    a_out_frozen: assert property (selectN |-> $stable(serialOut))
        else $error("serial output moved while deselected");
endmodule
`default_nettype wire

// File: verification/reference_level_serial_loader_tb_top.sv
// Testbench joining host and device ends of the level loader
`timescale 1ns/1ps
`default_nettype none
module reference_level_serial_loader_tb_top;
    import rlsl_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] regAddr = 2'h0;
    logic [15:0] regWdata = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [15:0] regRdata;
    logic refClk = 1'b0;
    logic [NUM_CHAN*LEVEL_W-1:0] levels, levels2;
    logic src, oe, oscOut, refStb, openStb, upd;
    logic [LEVEL_W-1:0] expLvl [NUM_CHAN];
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int updCount = 0;
    // Refresh pin level from both drivers
    wire pinLvl = oe ? oscOut : refClk;
    rlsl_link_if lnk ();
    rlsl_link_if lnk2 ();
    rlsl_host #(.HALF_CYC(4)) rlsl_host_i (.core_clk(core_clk),
        .rstn(rstn), .link(lnk.host), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata));
    rlsl_device #(.OSC_HALF(4)) rlsl_device_i (.core_clk(core_clk),
        .rstn(rstn), .link(lnk.device), .refreshClkIn(pinLvl),
        .refreshClkOut(oscOut), .refreshClkOe(oe), .channelLevels(levels),
        .clockSource(src), .refreshStrobe(refStb),
        .switchOpenStrobe(openStb), .updatePulse(upd));
    // Second device driven by hand with a whole frame, a short frame and clocks while deselected
    rlsl_device #(.OSC_HALF(4)) rlsl_device_i2 (.core_clk(core_clk),
        .rstn(rstn), .link(lnk2.device), .refreshClkIn(1'b0),
        .refreshClkOut(), .refreshClkOe(), .channelLevels(levels2),
        .clockSource(), .refreshStrobe(), .switchOpenStrobe(),
        .updatePulse());
    rlsl_props rlsl_props_i (.core_clk(core_clk), .rstn(rstn),
        .selectN(lnk.selectN), .shiftClk(lnk.shiftClk),
        .serialIn(lnk.serialIn), .serialOut(lnk.serialOut));
    // ==========================================================
    // Clock and hang guard
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            conclude();
        end
    end
    // Count update pulses of the chained device
    always @(posedge core_clk) begin
        if (upd === 1'b1) begin
            updCount++;
        end
    end
    // ==========================================================
    // Shared tasks
    task automatic conclude();
        if (n_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [1:0] a, output logic [15:0] d);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 d = regRdata;
        @(posedge core_clk);
    endtask
    task automatic waitStat(input int b);
        logic [15:0] s;
        s = 16'h0000;
        for (int t = 0; t < 300 && s[b] !== 1'b1; t++) rd(2'h2, s);
        chk(16'(s[b]), 16'h0001);
    endtask
    task automatic frame(input logic [15:0] w0, input logic [15:0] w1,
        input int m);
        int u;
        u = updCount;
        wr(2'h0, w0);
        wr(2'h1, 16'(m));
        if (m > 1) begin
            waitStat(1);
            wr(2'h0, w1);
        end
        waitStat(2);
        repeat (4) @(posedge core_clk);
        chk(16'(updCount - u), 16'h0001);
    endtask
    task automatic chkLv();
        for (int i = 0; i < NUM_CHAN; i++)
            chk(16'(levels[i*LEVEL_W +: LEVEL_W]), 16'(expLvl[i]));
    endtask
    task automatic cnt(output int nf, output int nr);
        nf = 0;
        nr = 0;
        for (int i = 0; i < 40; i++) begin
            refClk <= i[3];
            @(negedge core_clk);
            nf += refStb;
            nr += openStb;
            @(posedge core_clk);
        end
    endtask
    task automatic bang(input logic [15:0] w, input int n);
        lnk2.selectN <= 1'b0;
        repeat (4) @(posedge core_clk);
        for (int i = 15; i > 15 - n; i--) begin
            lnk2.serialIn <= w[i];
            repeat (4) @(posedge core_clk);
            lnk2.shiftClk <= 1'b1;
            repeat (4) @(posedge core_clk);
            lnk2.shiftClk <= 1'b0;
        end
        repeat (4) @(posedge core_clk);
        lnk2.selectN <= 1'b1;
        repeat (8) @(posedge core_clk);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        logic [15:0] s;
        chkLv();
        chk(16'({src, oe}), 16'h0000);
        rd(2'h2, s);
        chk(s, 16'h0000);
    endtask
    task automatic t_chain();
        logic [15:0] s;
        expLvl[9] = 10'h0ab;
        frame(16'h0955, 16'h24ab, 2);
        chkLv();
        rd(2'h3, s);
        chk(s, 16'h0955);
    endtask
    task automatic t_index();
        logic [9:0] lv;
        for (int i = 0; i < 16; i++) begin
            lv = 10'h2a5 ^ 10'(i * 37);
            if (i < NUM_CHAN) expLvl[i] = lv;
            frame({i == 5, i[0], i[3:0], lv}, 16'h0000, 1);
            chkLv();
            chk(16'(src), 16'(i[0]));
        end
    endtask
    task automatic t_refresh();
        int nf, nr;
        cnt(nf, nr);
        chk(16'(oe), 16'h0000);
        chk(16'(nf), 16'h0002);
        chk(16'(nr), 16'h0002);
        frame(16'h3000, 16'h0000, 1);
        chkLv();
        chk(16'(oe), 16'h0001);
        cnt(nf, nr);
        chk(16'(nf > 2 && nr > 2), 16'h0001);
    endtask
    task automatic t_short();
        logic so;
        bang(16'h4695, 16);
        chk(16'(levels2[LEVEL_W +: LEVEL_W]), 16'h0295);
        bang(16'h00ff, 8);
        chk(16'(levels2[LEVEL_W +: LEVEL_W]), 16'h0295);
        so = lnk2.serialOut;
        for (int i = 0; i < 32; i++) begin
            lnk2.shiftClk <= i[1];
            lnk2.serialIn <= i[0];
            @(posedge core_clk);
        end
        lnk2.shiftClk <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk(16'(lnk2.serialOut), 16'(so));
        chk(16'(levels2[LEVEL_W +: LEVEL_W]), 16'h0295);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        lnk2.selectN = 1'b1;
        lnk2.shiftClk = 1'b0;
        lnk2.serialIn = 1'b0;
        for (int i = 0; i < NUM_CHAN; i++) expLvl[i] = LEVEL_RST;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_chain();
        t_index();
        t_refresh();
        t_short();
        conclude();
    end
endmodule
`default_nettype wire
